// ===== verilog/uctx_pkg.sv
package uctx_pkg;

	// =====================================================================
	// command codes on the command port
	// =====================================================================
	typedef enum logic [3:0] {
		UCTX_CMD_NONE,
		UCTX_CMD_RX_EN,
		UCTX_CMD_RX_DIS,
		UCTX_CMD_TX_EN,
		UCTX_CMD_TX_DIS,
		UCTX_CMD_RX_RESET,
		UCTX_CMD_TX_RESET,
		UCTX_CMD_ERR_RESET,
		UCTX_CMD_BRK_START,
		UCTX_CMD_BRK_STOP
	} uctx_cmd_t;

	// =====================================================================
	// register offsets (byte addresses, one word each)
	// =====================================================================
	localparam logic [3:0] UCTX_OFS_MODE    = 4'h0;
	localparam logic [3:0] UCTX_OFS_STATUS  = 4'h4;
	localparam logic [3:0] UCTX_OFS_COMMAND = 4'h8;
	localparam logic [3:0] UCTX_OFS_DATA    = 4'hC;

	// mode register field positions
	localparam int UCTX_MODE_BITS_LO  = 0;
	localparam int UCTX_MODE_PAR_TYPE = 2;
	localparam int UCTX_MODE_PAR_LO   = 3;
	localparam int UCTX_MODE_ERR_BLK  = 5;
	localparam int UCTX_MODE_RX_INT   = 6;
	localparam int UCTX_MODE_RX_RTS   = 7;
	localparam int UCTX_MODE_STOP2    = 8;
	localparam int UCTX_MODE_CTS_EN   = 9;
	localparam int UCTX_MODE_TX_RTS   = 10;
	localparam int UCTX_MODE_X1       = 11;
	localparam logic [11:0] UCTX_MODE_RESET = 12'h003;

	// status register bit positions
	localparam int UCTX_ST_RX_CHAR_AVAILABLE_FLAG = 0;
	localparam int UCTX_ST_FULL  = 1;
	localparam int UCTX_ST_TX_HOLDING_FREE_FLAG = 2;
	localparam int UCTX_ST_TX_FULLY_DRAINED_FLAG = 3;
	localparam int UCTX_ST_OVR   = 4;
	localparam int UCTX_ST_PE    = 5;
	localparam int UCTX_ST_FE    = 6;
	localparam int UCTX_ST_BRK   = 7;

	// =====================================================================
	// timing and sizes
	// =====================================================================
	localparam int         UCTX_DEPTH     = 3;
	localparam logic [3:0] UCTX_QUAL_TICK = 4'h7;
	localparam logic [3:0] UCTX_BIT_TICKS = 4'hF;
	localparam logic [3:0] UCTX_HALF_TICK = 4'h7;
	localparam logic [1:0] UCTX_BRK_EDGES = 2'h2;

	// queue entry: data plus per-character error bits
	typedef struct packed {
		logic       brk;
		logic       fe;
		logic       pe;
		logic [7:0] data;
	} uctx_entry_t;

	typedef enum logic [2:0] {
		UCTX_TX_IDLE,
		UCTX_TX_START,
		UCTX_TX_DATA,
		UCTX_TX_PAR,
		UCTX_TX_STOP
	} uctx_tx_t;

	typedef enum logic [2:0] {
		UCTX_RX_HUNT,
		UCTX_RX_QUAL,
		UCTX_RX_DATA,
		UCTX_RX_PAR,
		UCTX_RX_STOP,
		UCTX_RX_REHUNT,
		UCTX_RX_BRK
	} uctx_rx_t;

endpackage : uctx_pkg

// ===== verilog/uctx_channel.sv
`timescale 1ns/1ps
// Functional notes
// [R1] holding register buffers one character ahead
// [R2] no holding load while transmitter disabled
// [R3] start, data lsb first, parity, stops
// [R4] idle marks high, drained flag set
// [R5] disable finishes the character in progress
// [R6] break command holds line low
// [R7] transmitter reset stops at once
// [R8] clear-to-send gates character start
// [R9] tx request-to-send drops one bit later
// [R10] start qualified at half bit
// [R11] finished character queued, ready flag set
// [R12] rehunt immediately, framing restart rule
// [R13] break loads zero, ends after high
// [R14] three-deep first-in-first-out queue
// [R15] ready and full flags, selectable interrupt
// [R16] data read pops, status read does not
// [R17] per-character error bits, overrun global
// [R18] character or block error reporting
// [R19] full queue holds one, then overrun
// [R20] rx request-to-send drops when full
// [R21] receiver disable drops partial character
// [R22] receiver reset realigns pointers, keeps data
// [R23] transmitter runs only after enable
// [R24] block errors clear by command only
// [R25] false start edge discarded
module uctx_channel
	import uctx_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	input  wire logic        baud_tick,
	input  wire logic        ref_clk_tick,
	input  wire logic [3:0]  addr,
	input  wire logic [11:0] wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [11:0] rdata,
	input  wire logic        serial_in,
	output logic             serial_out_line_chan_a,
	input  wire logic        clear_to_send_in_n,
	output logic             request_to_send_out_n,
	output logic             rx_irq
);

	// =====================================================================
	// state
	// =====================================================================
	typedef struct packed {
		logic [11:0] mode;        // format and control
		logic        tx_en;       // transmitter enabled
		logic        rx_en;       // receiver enabled
		logic        brk;         // break being sent
		logic        hold_full;   // holding register loaded
		logic [7:0]  hold;        // holding register
		uctx_tx_t    tx_st;       // transmit state
		logic [7:0]  tx_sh;       // transmit shift
		logic [3:0]  tx_tick;     // ticks within bit
		logic [2:0]  tx_bit;      // bit index
		logic        tx_par;      // running parity
		logic        tx_out;      // line level
		logic        rts_tx_arm;  // waiting to drop
		logic        rts;         // request asserted
		uctx_rx_t    rx_st;       // receive state
		logic [3:0]  rx_tick;
		logic [2:0]  rx_bit;
		logic [7:0]  rx_sh;
		logic        rx_par;
		logic        rx_prev;     // last sampled input
		logic        wait_full;   // char waiting in shift
		uctx_entry_t wait_ent;
		logic        ovr;         // overrun status
		logic [1:0]  brk_hi;      // ref edges seen high
		uctx_entry_t [UCTX_DEPTH-1:0] q;
		logic [1:0]  rd_ptr;
		logic [1:0]  wr_ptr;
		logic [1:0]  cnt;
		logic [2:0]  blk_err;     // accumulated errors
		logic [11:0] rdata;
	} uctx_state_t;

	uctx_state_t s;
	uctx_state_t next_s;

	// index of the last data bit from mode field
	function automatic logic [2:0] last_bit(input logic [1:0] sel);
		last_bit = 3'h4 + {1'b0, sel};
	endfunction : last_bit

	// wrap-around pointer step over three slots
	function automatic logic [1:0] ptr_inc(input logic [1:0] p);
		ptr_inc = (p == 2'h2) ? 2'h0 : p + 2'h1;
	endfunction : ptr_inc

	// parity bit for a running xor and mode
	function automatic logic par_bit(input logic x, input logic [11:0] m);
		par_bit = (m[UCTX_MODE_PAR_LO+:2] == 2'h1) ? m[UCTX_MODE_PAR_TYPE]
			: (x ^ m[UCTX_MODE_PAR_TYPE]);
	endfunction : par_bit

	logic        par_on;      // parity bit present
	logic        cmd_wr;      // command write
	uctx_cmd_t   cmd;         // decoded command
	logic        pop;         // data read pops queue
	uctx_entry_t head;        // queue head
	logic [2:0]  err_view;    // error bits shown
	logic        x1_mode;     // 1x clock mode
	logic        bit_end;     // transmit bit boundary
	logic        rx_mid;      // receive sample point

	assign par_on   = s.mode[UCTX_MODE_PAR_LO+1] == 1'b0;
	assign cmd_wr   = wr_stb && (addr == UCTX_OFS_COMMAND);
	assign cmd      = uctx_cmd_t'(wdata[3:0]);
	assign pop      = rd_stb && (addr == UCTX_OFS_DATA) && (s.cnt != 2'h0);
	assign head     = s.q[s.rd_ptr];
	assign x1_mode  = s.mode[UCTX_MODE_X1];
	assign bit_end  = baud_tick && (x1_mode || s.tx_tick == UCTX_BIT_TICKS);
	assign rx_mid   = baud_tick && (x1_mode || s.rx_tick == UCTX_BIT_TICKS);

	// [R18] character or block view
	assign err_view = s.mode[UCTX_MODE_ERR_BLK] ? s.blk_err
		: ((s.cnt != 2'h0) ? {head.brk, head.fe, head.pe} : 3'h0);

	// =====================================================================
	// next-state logic
	// =====================================================================
	always_comb begin
		next_s = s;
		next_s.rdata = 12'h000;
		// ---- bus reads ----
		if (rd_stb && addr == UCTX_OFS_MODE) begin
			next_s.rdata = s.mode;
		end else if (rd_stb && addr == UCTX_OFS_STATUS) begin
			// [R16] status read leaves queue alone
			next_s.rdata = {4'h0, err_view[2], err_view[1], err_view[0], s.ovr,
				!s.hold_full && s.tx_st == UCTX_TX_IDLE, !s.hold_full && s.tx_en,
				s.cnt == 2'h3, s.cnt != 2'h0};
		end else if (rd_stb && addr == UCTX_OFS_DATA) begin
			next_s.rdata = {4'h0, head.data};
		end
		// [R16] pop oldest character
		if (pop) begin
			next_s.rd_ptr = ptr_inc(s.rd_ptr);
			next_s.cnt    = s.cnt - 2'h1;
		end
		// ---- bus writes ----
		if (wr_stb && addr == UCTX_OFS_MODE) begin
			next_s.mode = wdata;
		end
		// [R2] loads refused while disabled
		if (wr_stb && addr == UCTX_OFS_DATA && s.tx_en && !s.hold_full) begin
			// [R1] load clears the free flag
			next_s.hold      = wdata[7:0];
			next_s.hold_full = 1'b1;
		end

		// ---- transmitter ----
		if (baud_tick && s.tx_st != UCTX_TX_IDLE) begin
			next_s.tx_tick = s.tx_tick + 4'h1;
		end
		case (s.tx_st)
			UCTX_TX_IDLE: begin
				// [R4] idle line marks
				next_s.tx_out = 1'b1;
				// [R8] start only with clear-to-send low
				if (baud_tick && next_s.hold_full
					&& !(s.mode[UCTX_MODE_CTS_EN] && clear_to_send_in_n)) begin
					// [R1] move holding into shift
					next_s.tx_sh     = next_s.hold;
					next_s.hold_full = 1'b0;
					next_s.tx_st     = UCTX_TX_START;
					next_s.tx_tick   = 4'h0;
					next_s.tx_par    = 1'b0;
					next_s.tx_out    = 1'b0;
					next_s.rts_tx_arm = 1'b0;
				end
			end
			UCTX_TX_START: begin
				// [R3] start bit then data
				if (bit_end) begin
					next_s.tx_st  = UCTX_TX_DATA;
					next_s.tx_bit = 3'h0;
					next_s.tx_out = s.tx_sh[0];
					next_s.tx_par = s.tx_sh[0];
				end
			end
			UCTX_TX_DATA: begin
				// [R3] lsb first, then parity
				if (bit_end) begin
					if (s.tx_bit == last_bit(s.mode[UCTX_MODE_BITS_LO+:2])) begin
						next_s.tx_st  = par_on ? UCTX_TX_PAR : UCTX_TX_STOP;
						next_s.tx_out = par_on ? par_bit(s.tx_par, s.mode) : 1'b1;
						next_s.tx_bit = 3'h0;
					end else begin
						next_s.tx_bit = s.tx_bit + 3'h1;
						next_s.tx_out = s.tx_sh[s.tx_bit + 3'h1];
						next_s.tx_par = s.tx_par ^ s.tx_sh[s.tx_bit + 3'h1];
					end
				end
			end
			UCTX_TX_PAR: begin
				if (bit_end) begin
					next_s.tx_st  = UCTX_TX_STOP;
					next_s.tx_out = 1'b1;
					next_s.tx_bit = 3'h0;
				end
			end
			UCTX_TX_STOP: begin
				// [R3] one or two stop bits
				if (bit_end) begin
					if (s.mode[UCTX_MODE_STOP2] && s.tx_bit == 3'h0) begin
						next_s.tx_bit = 3'h1;
					end else begin
						// [R5] back to idle; a loaded holding register still starts, even when disabled
						next_s.tx_st = UCTX_TX_IDLE;
					end
				end
			end
			default: next_s.tx_st = UCTX_TX_IDLE;
		endcase

		// [R9] drop request one bit after drain
		if (s.mode[UCTX_MODE_TX_RTS] && !s.tx_en && !s.hold_full
			&& s.tx_st == UCTX_TX_IDLE && s.rts) begin
			if (!s.rts_tx_arm) begin
				next_s.rts_tx_arm = 1'b1;
				next_s.tx_tick    = 4'h0;
			end else if (baud_tick) begin
				next_s.tx_tick = s.tx_tick + 4'h1;
				if (x1_mode || s.tx_tick == UCTX_BIT_TICKS) begin
					next_s.rts = 1'b0;
				end
			end
		end

		// ---- receiver ----
		if (baud_tick) begin
			next_s.rx_prev = serial_in;
			next_s.rx_tick = s.rx_tick + 4'h1;
		end
		case (s.rx_st)
			UCTX_RX_HUNT: begin
				// [R10] watch for falling edge
				if (baud_tick && s.rx_en && s.rx_prev && !serial_in) begin
					next_s.rx_st   = UCTX_RX_QUAL;
					next_s.rx_tick = 4'h0;
				end
			end
			UCTX_RX_QUAL: begin
				// [R10] qualify at half bit
				if (baud_tick && (x1_mode || s.rx_tick == UCTX_QUAL_TICK)) begin
					if (serial_in) begin
						// [R25] false start, hunt again
						next_s.rx_st = UCTX_RX_HUNT;
					end else begin
						next_s.rx_st   = UCTX_RX_DATA;
						next_s.rx_tick = 4'h0;
						next_s.rx_bit  = 3'h0;
						next_s.rx_sh   = 8'h00;
						next_s.rx_par  = 1'b0;
						// [R19] overrun flagged at new start
						if (s.wait_full) begin
							next_s.ovr = 1'b1;
						end
						// [R20] full queue drops request
						if (s.mode[UCTX_MODE_RX_RTS] && s.cnt == 2'h3) begin
							next_s.rts = 1'b0;
						end
					end
				end
			end
			UCTX_RX_DATA: begin
				if (rx_mid) begin
					next_s.rx_sh[s.rx_bit] = serial_in;
					next_s.rx_par = s.rx_par ^ serial_in;
					next_s.rx_bit = s.rx_bit + 3'h1;
					if (s.rx_bit == last_bit(s.mode[UCTX_MODE_BITS_LO+:2])) begin
						next_s.rx_st = par_on ? UCTX_RX_PAR : UCTX_RX_STOP;
					end
				end
			end
			UCTX_RX_PAR: begin
				if (rx_mid) begin
					next_s.rx_par = (serial_in != par_bit(s.rx_par, s.mode));
					next_s.rx_st  = UCTX_RX_STOP;
				end
			end
			UCTX_RX_STOP: begin
				if (rx_mid) begin
					// [R11] assembled character goes to queue
					// [R17] error bits travel with the character
					next_s.wait_full = 1'b1;
					next_s.wait_ent  = '{brk: 1'b0, fe: !serial_in,
						pe: par_on && s.rx_par, data: s.rx_sh};
					next_s.rx_tick   = 4'h0;
					if (!serial_in && s.rx_sh == 8'h00) begin
						// [R13] break loads zero character
						next_s.wait_ent.brk = 1'b1;
						next_s.wait_ent.pe  = 1'b0;
						next_s.rx_st  = UCTX_RX_BRK;
						next_s.brk_hi = 2'h0;
					end else if (!serial_in) begin
						next_s.rx_st = UCTX_RX_REHUNT;
					end else begin
						// [R12] hunt again immediately
						next_s.rx_st = UCTX_RX_HUNT;
					end
					if (s.wait_full) begin
						// [R19] older waiting character lost
						next_s.ovr = 1'b1;
					end
				end
			end
			UCTX_RX_REHUNT: begin
				// [R12] still low half bit on: new start
				if (baud_tick && (x1_mode || s.rx_tick == UCTX_HALF_TICK)) begin
					next_s.rx_st   = serial_in ? UCTX_RX_HUNT : UCTX_RX_QUAL;
					next_s.rx_tick = 4'h0;
					next_s.rx_bit  = 3'h0;
					next_s.rx_sh   = 8'h00;
					next_s.rx_par  = 1'b0;
				end
			end
			UCTX_RX_BRK: begin
				// [R13] end after two high reference edges
				if (!serial_in) begin
					next_s.brk_hi = 2'h0;
				end else if (ref_clk_tick) begin
					next_s.brk_hi = s.brk_hi + 2'h1;
					if (s.brk_hi + 2'h1 == UCTX_BRK_EDGES) begin
						next_s.rx_st = UCTX_RX_HUNT;
					end
				end
			end
			default: next_s.rx_st = UCTX_RX_HUNT;
		endcase

		// [R14] waiting char fills topmost empty slot
		if (s.wait_full && next_s.cnt != 2'h3) begin
			next_s.q[s.wr_ptr] = s.wait_ent;
			next_s.wr_ptr      = ptr_inc(s.wr_ptr);
			next_s.cnt         = next_s.cnt + 2'h1;
			// a character finishing this cycle keeps waiting, whatever state follows
			next_s.wait_full   = (s.rx_st == UCTX_RX_STOP) && rx_mid;
		end
		// [R20] request back once a slot frees
		if (s.mode[UCTX_MODE_RX_RTS] && !s.rts && next_s.cnt != 2'h3 && pop) begin
			next_s.rts = 1'b1;
		end
		// [R18] block view ORs chars reaching the head
		if (pop && s.cnt > 2'h1) begin
			next_s.blk_err = next_s.blk_err | {s.q[ptr_inc(s.rd_ptr)].brk,
				s.q[ptr_inc(s.rd_ptr)].fe, s.q[ptr_inc(s.rd_ptr)].pe};
		end
		if (s.cnt == 2'h0 && next_s.cnt != 2'h0) begin
			next_s.blk_err = next_s.blk_err | {s.wait_ent.brk, s.wait_ent.fe,
				s.wait_ent.pe};
		end

		// ---- commands, applied last ----
		if (cmd_wr) begin
			case (cmd)
				// [R23] transmitter enabled by command
				UCTX_CMD_TX_EN: begin
					next_s.tx_en = 1'b1;
					next_s.rts   = 1'b1;
				end
				UCTX_CMD_TX_DIS: next_s.tx_en = 1'b0;
				UCTX_CMD_RX_EN: next_s.rx_en = 1'b1;
				// [R21] disable drops partial character
				UCTX_CMD_RX_DIS: begin
					next_s.rx_en = 1'b0;
					next_s.rx_st = UCTX_RX_HUNT;
				end
				// [R6] break on and off
				UCTX_CMD_BRK_START: next_s.brk = 1'b1;
				UCTX_CMD_BRK_STOP: next_s.brk = 1'b0;
				// [R24] error reset clears accumulation
				UCTX_CMD_ERR_RESET: begin
					next_s.blk_err = 3'h0;
					next_s.ovr     = 1'b0;
				end
				// [R7] stop transmitter at once
				UCTX_CMD_TX_RESET: begin
					next_s.tx_en     = 1'b0;
					next_s.tx_st     = UCTX_TX_IDLE;
					next_s.hold_full = 1'b0;
					next_s.tx_out    = 1'b1;
					next_s.brk       = 1'b0;
				end
				// [R22] realign pointers, stored data kept
				UCTX_CMD_RX_RESET: begin
					next_s.rx_en     = 1'b0;
					next_s.rx_st     = UCTX_RX_HUNT;
					next_s.wait_full = 1'b0;
					next_s.rd_ptr    = next_s.wr_ptr;
					next_s.cnt       = 2'h0;
					next_s.blk_err   = 3'h0;
					next_s.ovr       = 1'b0;
					next_s.q[s.rd_ptr].pe  = 1'b0;
					next_s.q[s.rd_ptr].fe  = 1'b0;
					next_s.q[s.rd_ptr].brk = 1'b0;
				end
				default: next_s.tx_en = s.tx_en;
			endcase
		end
	end

	// =====================================================================
	// registers
	// =====================================================================
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s        <= '0;
			s.mode   <= UCTX_MODE_RESET;
			s.tx_out <= 1'b1;
			s.rx_prev <= 1'b1;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// [R6] break overrides the line
	assign serial_out_line_chan_a = s.tx_out && !s.brk;
	assign request_to_send_out_n  = !s.rts;
	assign rdata                  = s.rdata;
	// [R15] interrupt source selectable
	assign rx_irq = s.mode[UCTX_MODE_RX_INT] ? (s.cnt == 2'h3) : (s.cnt != 2'h0);

	// =====================================================================
	// checks
	// =====================================================================
	a_tx_refuse_load: assert property (@(posedge mclk) disable iff (!nrst) // [R2]
		(clk_en && !s.tx_en && !s.hold_full) |=> !s.hold_full)
		else $error("holding load while disabled");
	a_queue_depth_max: assert property (@(posedge mclk) disable iff (!nrst) // [R14]
		(s.cnt == 2'h3) |-> (s.rd_ptr == s.wr_ptr && s.wr_ptr != 2'h3))
		else $error("full queue pointers out of step");
	a_status_no_pop: assert property (@(posedge mclk) disable iff (!nrst) // [R16]
		(clk_en && rd_stb && addr == UCTX_OFS_STATUS && !s.wait_full) |=> $stable(s.cnt))
		else $error("status read moved queue");
	a_break_line_low: assert property (@(posedge mclk) disable iff (!nrst) // [R6]
		s.brk |-> !serial_out_line_chan_a)
		else $error("line high during break");
	a_idle_marks: assert property (@(posedge mclk) disable iff (!nrst) // [R4]
		(s.tx_st == UCTX_TX_IDLE && !s.brk) |-> serial_out_line_chan_a)
		else $error("idle line not marking");
	a_irq_full_sel: assert property (@(posedge mclk) disable iff (!nrst) // [R15]
		(s.mode[UCTX_MODE_RX_INT] && s.cnt == 2'h2) |-> !rx_irq)
		else $error("full interrupt too early");
	a_tx_reset_stop: assert property (@(posedge mclk) disable iff (!nrst) // [R7]
		(clk_en && cmd_wr && cmd == UCTX_CMD_TX_RESET) |=> (s.tx_st == UCTX_TX_IDLE && !s.tx_en))
		else $error("transmitter reset ignored");
	a_rx_dis_stop: assert property (@(posedge mclk) disable iff (!nrst) // [R21]
		(clk_en && cmd_wr && cmd == UCTX_CMD_RX_DIS) |=> s.rx_st == UCTX_RX_HUNT)
		else $error("receiver kept assembling");

endmodule : uctx_channel

// ===== verif/uctx_remote.sv
`timescale 1ns/1ps
// =====================================================================
// remote serial device facing the channel
// =====================================================================
module uctx_remote
	import uctx_pkg::*;
(
	input  wire logic mclk,
	input  wire logic baud_tick,
	input  wire logic line_in,
	output logic      line_out
);
	logic [7:0] cap_q[$];	// characters captured from the channel
	logic [7:0] rx_sh;	// receive assembly

	// idle line marks high
	initial line_out = 1'b1;

	// wait a number of 16x ticks
	task automatic ticks(input int n);
		repeat (n) @(posedge mclk iff baud_tick);
	endtask : ticks

	task automatic send_char(input logic [7:0] c);
		logic [9:0] fr;
		fr = {1'b1, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out <= fr[i];
			ticks(16);
		end
	endtask : send_char

	// low pulse far shorter than half a bit, must not start a character
	task automatic glitch();
		line_out <= 1'b0;
		ticks(3);
		line_out <= 1'b1;
		ticks(32);
	endtask : glitch

	// receiver samples at mid bit, so short low pulses are dropped
	initial begin
		forever begin
			@(negedge line_in);
			ticks(8);
			if (line_in === 1'b0) begin
				for (int i = 0; i < 8; i++) begin
					ticks(16);
					rx_sh[i] = line_in;
				end
				ticks(16);
				cap_q.push_back(rx_sh);
			end
		end
	end
endmodule : uctx_remote

// ===== verif/uctx_channel_tb_top.sv
`timescale 1ns/1ps
// =====================================================================
// channel testbench
// =====================================================================
module uctx_channel_tb_top;
	import uctx_pkg::*;

	logic        mclk, nrst, baud_tick, ref_clk_tick;
	logic [3:0]  addr;
	logic [11:0] wdata, rdata, rd_val;
	logic        wr_stb, rd_stb, serial_in, line, cts_n, rts_n, rx_irq, clk_en;
	int          mismatches, check_count;
	logic [7:0]  rows [4][2];	// tx byte, rx byte

	uctx_channel uctx_channel_inst (
		.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .baud_tick(baud_tick),
		.ref_clk_tick(ref_clk_tick), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .serial_in(serial_in),
		.serial_out_line_chan_a(line), .clear_to_send_in_n(cts_n),
		.request_to_send_out_n(rts_n), .rx_irq(rx_irq));

	uctx_remote uctx_remote_inst (
		.mclk(mclk), .baud_tick(baud_tick), .line_in(line), .line_out(serial_in));

	// 20 mhz clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// tick every other cycle, so one bit is 32 clocks
	always @(posedge mclk) baud_tick <= ~baud_tick;
	always @(posedge mclk) ref_clk_tick <= ~ref_clk_tick;

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1 rd_val = rdata;
	endtask : rd

	task automatic cmd(input uctx_cmd_t c);
		wr(UCTX_OFS_COMMAND, {8'h00, c});
	endtask : cmd

	// bounded wait for the remote to capture n characters
	task automatic wait_cap(input int n);
		for (int k = 0; k < 3000 && uctx_remote_inst.cap_q.size() < n; k++) @(posedge mclk);
	endtask : wait_cap

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	// watchdog, well beyond the expected run of some 6200 clocks
	initial begin
		#3000000;
		mismatches++;
		summarize();
	end

	initial begin
		nrst = 1'b0; baud_tick = 1'b0; ref_clk_tick = 1'b0; addr = 4'h0;
		wdata = 12'h000; wr_stb = 1'b0; rd_stb = 1'b0; cts_n = 1'b0; clk_en = 1'b1;
		mismatches = 0; check_count = 0;
		rows = '{'{8'h55, 8'hA3}, '{8'h00, 8'hFF}, '{8'hFF, 8'h01}, '{8'h80, 8'h7E}};
		repeat (12) @(posedge mclk);
		chk({11'h000, line}, 12'h001);
		chk({11'h000, rts_n}, 12'h001);
		nrst <= 1'b1;
		// 8 bits, no parity, character errors, ready interrupt
		wr(UCTX_OFS_MODE, 12'h013);
		wr(UCTX_OFS_DATA, 12'h0AA);
		repeat (400) @(posedge mclk);
		chk(12'(uctx_remote_inst.cap_q.size()), 12'h000);
		cmd(UCTX_CMD_RX_EN);
		cmd(UCTX_CMD_TX_EN);
		foreach (rows[i]) begin
			uctx_remote_inst.send_char(rows[i][1]);
			repeat (8) @(posedge mclk);
			rd(UCTX_OFS_STATUS);
			chk(rd_val & 12'h001, 12'h001);
			chk({11'h000, rx_irq}, 12'h001);
			rd(UCTX_OFS_DATA);
			chk({4'h0, rd_val[7:0]}, {4'h0, rows[i][1]});
			wr(UCTX_OFS_DATA, {4'h0, rows[i][0]});
			wait_cap(i + 1);
			chk({4'h0, uctx_remote_inst.cap_q[i]}, {4'h0, rows[i][0]});
			repeat (80) @(posedge mclk);
			rd(UCTX_OFS_STATUS);
			chk(rd_val & 12'h00D, 12'h00C);
		end
		cmd(UCTX_CMD_TX_DIS);
		wr(UCTX_OFS_DATA, 12'h0A5);
		repeat (400) @(posedge mclk);
		chk(12'(uctx_remote_inst.cap_q.size()), 12'h004);
		cmd(UCTX_CMD_TX_EN);
		cmd(UCTX_CMD_BRK_START);
		repeat (4) @(posedge mclk);
		chk({11'h000, line}, 12'h000);
		cmd(UCTX_CMD_BRK_STOP);
		repeat (4) @(posedge mclk);
		chk({11'h000, line}, 12'h001);
		// frozen clock enable drops the break command
		clk_en <= 1'b0;
		cmd(UCTX_CMD_BRK_START);
		repeat (4) @(posedge mclk);
		chk({11'h000, line}, 12'h001);
		clk_en <= 1'b1;
		// clear-to-send high holds the next character back
		wr(UCTX_OFS_MODE, 12'h2D3);
		cts_n <= 1'b1;
		wr(UCTX_OFS_DATA, 12'h05A);
		repeat (400) @(posedge mclk);
		chk(12'(uctx_remote_inst.cap_q.size()), 12'h004);
		cts_n <= 1'b0;
		wait_cap(5);
		chk({4'h0, uctx_remote_inst.cap_q[4]}, 12'h05A);
		// five characters into a three-deep queue
		for (int c = 1; c <= 5; c++) uctx_remote_inst.send_char(8'(c));
		repeat (8) @(posedge mclk);
		rd(UCTX_OFS_STATUS);
		chk(rd_val & 12'h013, 12'h013);
		chk({11'h000, rts_n}, 12'h001);
		chk({11'h000, rx_irq}, 12'h001);
		// status read leaves the queue alone
		rd(UCTX_OFS_STATUS);
		chk(rd_val & 12'h013, 12'h013);
		for (int c = 1; c <= 3; c++) begin
			rd(UCTX_OFS_DATA);
			chk({4'h0, rd_val[7:0]}, 12'(c));
		end
		chk({11'h000, rts_n}, 12'h000);
		chk({11'h000, rx_irq}, 12'h000);
		// receiver reset empties the ready flag
		cmd(UCTX_CMD_ERR_RESET);
		cmd(UCTX_CMD_RX_RESET);
		repeat (2) @(posedge mclk);
		rd(UCTX_OFS_STATUS);
		chk(rd_val & 12'h013, 12'h000);
		chk({11'h000, rx_irq}, 12'h000);
		// short pulse is a false start
		cmd(UCTX_CMD_RX_EN);
		uctx_remote_inst.glitch();
		rd(UCTX_OFS_STATUS);
		chk(rd_val & 12'h001, 12'h000);
		// unmapped address reads zero
		rd(4'h2);
		chk(rd_val, 12'h000);
		// request drops one bit after the drain
		wr(UCTX_OFS_MODE, 12'h413);
		cmd(UCTX_CMD_TX_DIS);
		chk({11'h000, rts_n}, 12'h000);
		repeat (24) @(posedge mclk);
		chk({11'h000, rts_n}, 12'h000);
		repeat (16) @(posedge mclk);
		chk({11'h000, rts_n}, 12'h001);
		summarize();
	end
endmodule : uctx_channel_tb_top
